// ---- logic/tcpc_pkg.sv ----
// package for the transmit, clock output and frame handler register bank
// assumes one clock, the crystal reference, and a synchronous active-low reset
package tcpc_pkg;
  // register addresses (decimal 26 to 31)
  localparam logic [4:0] ADDR_TX_FILTER_POWER = 5'h1A;
  localparam logic [4:0] ADDR_CLOCK_OUTPUT_CONTROL = 5'h1B;
  localparam logic [4:0] ADDR_FRAME_CODING_LENGTH = 5'h1C;
  localparam logic [4:0] ADDR_LOCAL_STATION_ADDRESS = 5'h1D;
  localparam logic [4:0] ADDR_FRAME_OPTIONS_STATUS = 5'h1E;
  localparam logic [4:0] ADDR_BUFFER_OPTIONS = 5'h1F;
  // reset values
  localparam logic [7:0] RST_TX_FILTER_POWER = 8'h72;
  localparam logic [7:0] RST_CLOCK_OUTPUT_CONTROL = 8'hBC;
  localparam logic [7:0] RST_FRAME_CODING_LENGTH = 8'h00;
  localparam logic [7:0] RST_LOCAL_STATION_ADDRESS = 8'h00;
  localparam logic [7:0] RST_FRAME_OPTIONS_STATUS = 8'h48;
  localparam logic [7:0] RST_BUFFER_OPTIONS = 8'h00;
  // field positions
  localparam int CUTOFF_LSB = 4;
  localparam int POWER_LSB = 1;
  localparam int CLKOUT_ON_BIT = 7;
  localparam int CLKOUT_DIV_LSB = 2;
  localparam int MANCHESTER_BIT = 7;
  localparam int PAYLOAD_LSB = 0;
  localparam int VARLEN_BIT = 7;
  localparam int PREAMBLE_LSB = 5;
  localparam int WHITEN_BIT = 4;
  localparam int CRC_ON_BIT = 3;
  localparam int ADDR_FILT_LSB = 1;
  localparam int CRC_STATUS_BIT = 0;
  localparam int AUTOCLR_OFF_BIT = 7;
  localparam int STBY_READ_BIT = 6;
  // address filter modes and broadcast codes
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_NODE = 2'h1;
  localparam logic [1:0] FILT_NODE_ZERO = 2'h2;
  localparam logic [1:0] FILT_NODE_ZERO_ONES = 2'h3;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hFF;
  // configuration seen by the transmitter, receiver and buffer logic
  typedef struct packed {
    logic [3:0] interp_cutoff;
    logic [2:0] tx_power;
    logic clkout_on;
    logic [4:0] clkout_div;
    logic manchester_on;
    logic [6:0] payload_len;
    logic [7:0] node_addr;
    logic variable_len;
    logic [2:0] preamble_bytes;
    logic whitening_on;
    logic crc_on;
    logic [1:0] addr_filt;
    logic autoclr_off;
    logic stby_read;
  } tcpc_cfg_t;
endpackage

// ---- logic/tcpc_regs.sv ----
// register bank: transmit filter and power, clock output, frame handler settings
// assumes the serial port decoder and packet engine run on the crystal clock
`timescale 1ns/1ps
module tcpc_regs
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register access from the serial port decoder
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // packet engine events
  input wire logic crc_done,
  input wire logic crc_pass,
  input wire logic rx_addr_valid,
  input wire logic [7:0] rx_addr,
  output logic addr_result_valid,
  output logic addr_accept,
  output logic fifo_flush,
  // configuration and clock output pin
  output tcpc_pkg::tcpc_cfg_t cfg,
  output logic clkout
);

  logic [7:0] r26_q, r26_d;
  logic [7:0] r27_q, r27_d;
  logic [7:0] r28_q, r28_d;
  logic [7:0] r29_q, r29_d;
  logic [7:0] r30_q, r30_d;
  logic [7:0] r31_q, r31_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q;
  logic flush_q;
  logic accept_q;
  logic aval_q;
  logic [4:0] cnt_q, cnt_d;
  logic tog_q, tog_d;

  // address filter decision
  function automatic logic filt_ok(input logic [1:0] mode, input logic [7:0] node,
                                   input logic [7:0] a);
    begin
      case (mode)
        tcpc_pkg::FILT_OFF: filt_ok = 1'b1;
        tcpc_pkg::FILT_NODE: filt_ok = (a == node);
        tcpc_pkg::FILT_NODE_ZERO: filt_ok = (a == node) || (a == tcpc_pkg::BCAST_ZERO);
        default: filt_ok = (a == node) || (a == tcpc_pkg::BCAST_ZERO)
                           || (a == tcpc_pkg::BCAST_ONES);
      endcase
    end
  endfunction

  // write decode
  wire logic wr26 = reg_wr && (reg_addr == tcpc_pkg::ADDR_TX_FILTER_POWER);
  wire logic wr27 = reg_wr && (reg_addr == tcpc_pkg::ADDR_CLOCK_OUTPUT_CONTROL);
  wire logic wr28 = reg_wr && (reg_addr == tcpc_pkg::ADDR_FRAME_CODING_LENGTH);
  wire logic wr29 = reg_wr && (reg_addr == tcpc_pkg::ADDR_LOCAL_STATION_ADDRESS);
  wire logic wr30 = reg_wr && (reg_addr == tcpc_pkg::ADDR_FRAME_OPTIONS_STATUS);
  wire logic wr31 = reg_wr && (reg_addr == tcpc_pkg::ADDR_BUFFER_OPTIONS);

  // checksum result is updated only by the packet engine
  wire logic crc_bit_d = crc_done ? crc_pass : r30_q[tcpc_pkg::CRC_STATUS_BIT];
  wire logic [6:0] r30_hi_d = wr30 ? reg_wdata[7:1] : r30_q[7:1];

  assign r26_d = wr26 ? reg_wdata : r26_q;
  assign r27_d = wr27 ? reg_wdata : r27_q;
  assign r28_d = wr28 ? reg_wdata : r28_q;
  assign r29_d = wr29 ? reg_wdata : r29_q;
  assign r30_d = {r30_hi_d, crc_bit_d};
  assign r31_d = wr31 ? reg_wdata : r31_q;

  // read decode, unmapped addresses read as zero
  assign rdata_d =
    (reg_addr == tcpc_pkg::ADDR_TX_FILTER_POWER) ? r26_q :
    (reg_addr == tcpc_pkg::ADDR_CLOCK_OUTPUT_CONTROL) ? r27_q :
    (reg_addr == tcpc_pkg::ADDR_FRAME_CODING_LENGTH) ? r28_q :
    (reg_addr == tcpc_pkg::ADDR_LOCAL_STATION_ADDRESS) ? r29_q :
    (reg_addr == tcpc_pkg::ADDR_FRAME_OPTIONS_STATUS) ? r30_q :
    (reg_addr == tcpc_pkg::ADDR_BUFFER_OPTIONS) ? r31_q : 8'h00;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      r26_q <= tcpc_pkg::RST_TX_FILTER_POWER;
      r27_q <= tcpc_pkg::RST_CLOCK_OUTPUT_CONTROL;
      r28_q <= tcpc_pkg::RST_FRAME_CODING_LENGTH;
      r29_q <= tcpc_pkg::RST_LOCAL_STATION_ADDRESS;
      r30_q <= tcpc_pkg::RST_FRAME_OPTIONS_STATUS;
      r31_q <= tcpc_pkg::RST_BUFFER_OPTIONS;
    end
    else
    begin
      r26_q <= r26_d;
      r27_q <= r27_d;
      r28_q <= r28_d;
      r29_q <= r29_d;
      r30_q <= r30_d;
      r31_q <= r31_d;
    end
  end

  // read data and packet event outputs
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      flush_q <= 1'b0;
      accept_q <= 1'b0;
      aval_q <= 1'b0;
    end
    else
    begin
      rdata_q <= reg_rd ? rdata_d : rdata_q;
      rvalid_q <= reg_rd;
      flush_q <= crc_done && !crc_pass && !r31_q[tcpc_pkg::AUTOCLR_OFF_BIT];
      accept_q <= rx_addr_valid && filt_ok(cfg.addr_filt, cfg.node_addr, rx_addr);
      aval_q <= rx_addr_valid;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign fifo_flush = flush_q;
  assign addr_accept = accept_q;
  assign addr_result_valid = aval_q;

  // configuration fields
  assign cfg.interp_cutoff = r26_q[tcpc_pkg::CUTOFF_LSB +: 4];
  assign cfg.tx_power = r26_q[tcpc_pkg::POWER_LSB +: 3];
  assign cfg.clkout_on = r27_q[tcpc_pkg::CLKOUT_ON_BIT];
  assign cfg.clkout_div = r27_q[tcpc_pkg::CLKOUT_DIV_LSB +: 5];
  assign cfg.manchester_on = r28_q[tcpc_pkg::MANCHESTER_BIT];
  assign cfg.payload_len = r28_q[tcpc_pkg::PAYLOAD_LSB +: 7];
  assign cfg.node_addr = r29_q;
  assign cfg.variable_len = r30_q[tcpc_pkg::VARLEN_BIT];
  assign cfg.preamble_bytes = {1'b0, r30_q[tcpc_pkg::PREAMBLE_LSB +: 2]} + 3'h1;
  assign cfg.whitening_on = r30_q[tcpc_pkg::WHITEN_BIT];
  assign cfg.crc_on = r30_q[tcpc_pkg::CRC_ON_BIT];
  assign cfg.addr_filt = r30_q[tcpc_pkg::ADDR_FILT_LSB +: 2];
  assign cfg.autoclr_off = r31_q[tcpc_pkg::AUTOCLR_OFF_BIT];
  assign cfg.stby_read = r31_q[tcpc_pkg::STBY_READ_BIT];

  // clock output divider: toggle every N crystal cycles gives crystal over 2N; N of 0 passes the crystal clock straight through
  wire logic div_zero = (cfg.clkout_div == 5'h00);
  wire logic cnt_end = (cnt_q >= (cfg.clkout_div - 5'h01));
  assign cnt_d = (div_zero || cnt_end) ? 5'h00 : cnt_q + 5'h01;
  assign tog_d = div_zero ? 1'b0 : (cnt_end ? !tog_q : tog_q);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_q <= 5'h00;
      tog_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tog_q <= tog_d;
    end
  end

  assign clkout = cfg.clkout_on && (div_zero ? clk : tog_q);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_reset_cutoff;
    $rose(resetn) |-> (cfg.interp_cutoff == 4'h7) && (cfg.tx_power == 3'h1);
  endproperty
  a_reset_cutoff: assert property (p_reset_cutoff) else $error("bad transmit reset");

  property p_power_write;
    wr26 |=> cfg.tx_power == $past(reg_wdata[3:1]);
  endproperty
  a_power_write: assert property (p_power_write) else $error("power not stored");

  property p_clkout_off;
    !cfg.clkout_on |-> !clkout;
  endproperty
  a_clkout_off: assert property (p_clkout_off) else $error("clock out not gated");

  property p_div_period;
    (cfg.clkout_div == 5'h02) && $stable(cfg.clkout_div) && $changed(tog_q)
      |-> ##1 !$changed(tog_q) ##1 $changed(tog_q);
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider period wrong");

  property p_addr_write;
    wr29 |=> cfg.node_addr == $past(reg_wdata);
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("address not stored");

  property p_preamble;
    (cfg.preamble_bytes != 3'h0) && (cfg.preamble_bytes <= 3'h4);
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble count wrong");

  property p_filter;
    rx_addr_valid && (cfg.addr_filt == 2'h1) && (rx_addr != cfg.node_addr)
      |=> addr_result_valid && !addr_accept;
  endproperty
  a_filter: assert property (p_filter) else $error("address filter accepted");

  property p_crc_ro;
    wr30 && !crc_done |=> r30_q[0] == $past(r30_q[0]);
  endproperty
  a_crc_ro: assert property (p_crc_ro) else $error("checksum bit written");

  property p_flush;
    crc_done && !crc_pass |=> fifo_flush == !$past(cfg.autoclr_off);
  endproperty
  a_flush: assert property (p_flush) else $error("flush wrong");

  property p_stby;
    wr31 |=> cfg.stby_read == $past(reg_wdata[6]);
  endproperty
  a_stby: assert property (p_stby) else $error("standby direction wrong");

  property p_reset_clkout;
    $rose(resetn) |-> cfg.clkout_on && (cfg.clkout_div == 5'h0F);
  endproperty
  a_reset_clkout: assert property (p_reset_clkout) else $error("bad clock out reset");

  property p_reset_frame;
    $rose(resetn) |-> !cfg.manchester_on && (cfg.payload_len == 7'h00) && (cfg.node_addr == 8'h00);
  endproperty
  a_reset_frame: assert property (p_reset_frame) else $error("bad frame reset");

  property p_reset_options;
    $rose(resetn) |-> !cfg.variable_len && (cfg.preamble_bytes == 3'h3) && !cfg.whitening_on;
  endproperty
  a_reset_options: assert property (p_reset_options) else $error("bad options reset");

  property p_reset_crc_on;
    $rose(resetn) |-> cfg.crc_on && (cfg.addr_filt == 2'h0);
  endproperty
  a_reset_crc_on: assert property (p_reset_crc_on) else $error("bad checksum reset");

  property p_reset_buffer;
    $rose(resetn) |-> !cfg.autoclr_off && !cfg.stby_read;
  endproperty
  a_reset_buffer: assert property (p_reset_buffer) else $error("bad buffer reset");

  property p_cutoff_write;
    wr26 |=> cfg.interp_cutoff == $past(reg_wdata[7:4]);
  endproperty
  a_cutoff_write: assert property (p_cutoff_write) else $error("cutoff not stored");

  property p_clkout_write;
    wr27 |=> (cfg.clkout_on == $past(reg_wdata[7]))
      && (cfg.clkout_div == $past(reg_wdata[6:2]));
  endproperty
  a_clkout_write: assert property (p_clkout_write) else $error("clock out not stored");

  property p_manchester_write;
    wr28 |=> cfg.manchester_on == $past(reg_wdata[7]);
  endproperty
  a_manchester_write: assert property (p_manchester_write) else $error("coding not stored");

  property p_payload_write;
    wr28 |=> cfg.payload_len == $past(reg_wdata[6:0]);
  endproperty
  a_payload_write: assert property (p_payload_write) else $error("length not stored");

  property p_varlen_write;
    wr30 |=> cfg.variable_len == $past(reg_wdata[7]);
  endproperty
  a_varlen_write: assert property (p_varlen_write) else $error("format not stored");

  property p_whiten_write;
    wr30 |=> cfg.whitening_on == $past(reg_wdata[4]);
  endproperty
  a_whiten_write: assert property (p_whiten_write) else $error("whitening not stored");

  property p_crc_on_write;
    wr30 |=> cfg.crc_on == $past(reg_wdata[3]);
  endproperty
  a_crc_on_write: assert property (p_crc_on_write) else $error("checksum enable not stored");

  property p_autoclr_write;
    wr31 |=> cfg.autoclr_off == $past(reg_wdata[7]);
  endproperty
  a_autoclr_write: assert property (p_autoclr_write) else $error("flush enable not stored");

  property p_crc_update;
    crc_done |=> r30_q[0] == $past(crc_pass);
  endproperty
  a_crc_update: assert property (p_crc_update) else $error("checksum result lost");

  property p_filter_off;
    rx_addr_valid && (cfg.addr_filt == 2'h0) |=> addr_result_valid && addr_accept;
  endproperty
  a_filter_off: assert property (p_filter_off) else $error("filter off rejected");

  property p_filter_ones;
    rx_addr_valid && (cfg.addr_filt == 2'h3) && (rx_addr == 8'hFF) |=> addr_accept;
  endproperty
  a_filter_ones: assert property (p_filter_ones) else $error("all ones rejected");

  property p_filter_zero_only;
    rx_addr_valid && (cfg.addr_filt == 2'h2) && (rx_addr == 8'hFF) && (cfg.node_addr != 8'hFF)
      |=> !addr_accept;
  endproperty
  a_filter_zero_only: assert property (p_filter_zero_only) else $error("all ones accepted");

  property p_flush_cause;
    fifo_flush |-> $past(crc_done) && !$past(crc_pass) && !$past(cfg.autoclr_off);
  endproperty
  a_flush_cause: assert property (p_flush_cause) else $error("flush without failure");

  property p_clkout_run;
    cfg.clkout_on && (cfg.clkout_div == 5'h01) && $stable(cfg.clkout_div) && $stable(cfg.clkout_on)
      |-> $changed(clkout);
  endproperty
  a_clkout_run: assert property (p_clkout_run) else $error("clock out stalled");

  property p_preamble_one;
    (r30_q[6:5] == 2'h0) |-> cfg.preamble_bytes == 3'h1;
  endproperty
  a_preamble_one: assert property (p_preamble_one) else $error("short preamble wrong");

  property p_preamble_four;
    (r30_q[6:5] == 2'h3) |-> cfg.preamble_bytes == 3'h4;
  endproperty
  a_preamble_four: assert property (p_preamble_four) else $error("long preamble wrong");

  c_flush: cover property (crc_done && !crc_pass ##1 fifo_flush);
  c_accept: cover property (rx_addr_valid && cfg.addr_filt == 2'h3 ##1 addr_accept);
  c_read: cover property (reg_rd && reg_addr == tcpc_pkg::ADDR_FRAME_OPTIONS_STATUS);
  c_clkout: cover property (cfg.clkout_on && $changed(clkout));
  c_keep: cover property (crc_done && !crc_pass && cfg.autoclr_off);

endmodule

// ---- tb/tb_tx_clkout_packet_config_regs.sv ----
// bench for the register bank: host model plus packet engine events
// assumes a 10 MHz clock and a synchronous active-low reset
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_tx_clkout_packet_config_regs;
  logic clk, resetn, reg_wr, reg_rd, reg_rvalid, crc_done, crc_pass, rx_addr_valid;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_addr, v;
  logic addr_result_valid, addr_accept, fifo_flush, clkout, st;
  tcpc_pkg::tcpc_cfg_t cfg;
  logic [7:0] sh [6];
  integer seed, failures, tests_run, n, k;
  tcpc_regs dut_u (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rvalid, .crc_done, .crc_pass, .rx_addr_valid, .rx_addr, .addr_result_valid,
    .addr_accept, .fifo_flush, .cfg, .clkout);
  tcpc_host host_u (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid);
  function automatic tcpc_pkg::tcpc_cfg_t exp_cfg();
    exp_cfg = {sh[0][7:4], sh[0][3:1], sh[1][7], sh[1][6:2], sh[2], sh[3], sh[4][7],
      3'(sh[4][6:5]) + 3'h1, sh[4][4:1], sh[5][7:6]};
  endfunction
  function automatic logic acc(input logic [1:0] m, input logic [7:0] a);
    acc = m == 2'h0 || a == sh[3] || (m[1] && a == 8'h00) || (m == 2'h3 && a == 8'hFF);
  endfunction
  task automatic wreg(input integer i, input logic [7:0] d);
    sh[i] = d & ~((i == 0) ? 8'h01 : (i == 1) ? 8'h03 : (i == 5) ? 8'h3F : 8'h00);
    host_u.wr(5'(26 + i), sh[i]);
  endtask
  task automatic rchk(input integer i);
    host_u.rd(5'(26 + i), v);
    `CHK(v, ((i == 4) ? {sh[4][7:1], st} : sh[i]))
  endtask
  // length of one high run of the clock output, 0 if none
  task automatic halfp(output integer p);
    integer z;
    p = 0;
    z = 0;
    repeat (100)
    begin
      @(posedge clk);
      #1;
      if (clkout !== 1'b1)
      begin
        if (p > 0) break;
        z = 1;
      end
      else if (z == 1) p++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    seed = 32'hE65C3DDC;
    failures = 0;
    tests_run = 0;
    resetn = 1'b0;
    {crc_done, crc_pass, rx_addr_valid, rx_addr, st} = 12'h000;
    sh = '{{4'h7, 3'h1, 1'h0}, {1'h1, 5'h0F, 2'h0}, 8'h00, 8'h00,
      {1'h0, 2'h2, 1'h0, 1'h1, 2'h0, 1'h0}, 8'h00};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 6; n++) rchk(n);
    `CHK(cfg, exp_cfg())
    repeat (8)
    begin
      for (n = 0; n < 6; n++) wreg(n, 8'($random(seed)));
      for (n = 0; n < 6; n++) rchk(n);
      `CHK(cfg, exp_cfg())
    end
    host_u.wr(5'h05, 8'hA5);
    host_u.rd(5'h05, v);
    `CHK(v, 8'h00)
    for (n = 0; n < 4; n++)
    begin
      wreg(5, {n[1], sh[5][6:0]});
      crc_pass <= n[0];
      crc_done <= 1'b1;
      @(posedge clk);
      crc_done <= 1'b0;
      st = n[0];
      #1;
      `CHK(fifo_flush, (!n[1] && !n[0]))
      @(posedge clk);
      #1;
      `CHK(fifo_flush, 1'b0)
      @(posedge clk);
      rchk(4);
      wreg(4, sh[4] ^ 8'h01);
      rchk(4);
    end
    for (n = 0; n < 16; n++)
    begin
      if (n[1:0] == 2'h0)
      begin
        wreg(3, 8'($random(seed)));
        wreg(4, {sh[4][7:3], 2'(n[3:2]), 1'b0});
      end
      v = n[1:0] == 0 ? sh[3] : n[1:0] == 1 ? 8'h00 : n[1:0] == 2 ? 8'hFF : 8'($random(seed));
      rx_addr <= v;
      rx_addr_valid <= 1'b1;
      @(posedge clk);
      rx_addr_valid <= 1'b0;
      #1;
      `CHK({addr_result_valid, addr_accept}, {1'b1, acc(n[3:2], v)})
      @(posedge clk);
    end
    for (n = 0; n < 3; n++)
    begin
      v = n == 0 ? 8'h0C : n == 1 ? 8'h84 : 8'hFC;
      wreg(1, v);
      halfp(k);
      `CHK(k, (v[7] ? 32'(v[6:2]) : 0))
      @(posedge clk);
    end
    wreg(1, 8'h80);
    @(negedge clk);
    #1;
    `CHK(clkout, 1'b0)
    @(posedge clk);
    #1;
    `CHK(clkout, 1'b1)
    @(posedge clk);
    end_sim();
  end
endmodule

// ---- tb/tcpc_host.sv ----
// host model: byte writes and reads into the register bank
// assumes the bank samples its strobes on the rising edge of clk
`timescale 1ns/1ps
module tcpc_host
(
  // clock
  input wire logic clk,
  // register port
  output logic [4:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // one write; the caller keeps reserved bits at their defaults
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clk);
  endtask
  // one read; unknown unless the answer came one cycle on
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    @(posedge clk);
  endtask
endmodule
